// File: spc_cfg.svh
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// byte geometry
`define SPC_BYTE_BITS 8
`define SPC_LAST_BIT 3'h7
`define SPC_RX_DEPTH 8
`define SPC_SYNC_STAGES 2

// flag positions in the flag register
`define SPC_F_XFER 0
`define SPC_F_WCOL 1
`define SPC_F_SSI 2
`define SPC_F_DRE 3
`define SPC_F_RXC 4
`define SPC_F_TXC 5
`define SPC_NFLAGS 6

// reset values
`define SPC_FLAGS_RST 6'h08
`define SPC_SHREG_RST 8'h00

// sources valid per mode
`define SPC_NORMAL_SRC 6'h03
`define SPC_BUFFER_SRC 6'h3c

`endif

// File: spc_pkg.sv
`default_nettype none
package spc_pkg;
    // post-transfer sequencer, gray along idle-shift-rxc-txc
    typedef enum logic [1:0]
    {
        SPC_IDLE = 2'b00,
        SPC_SHIFT = 2'b01,
        SPC_RXC = 2'b11,
        SPC_TXC = 2'b10
    } spc_state_t;
    typedef logic [7:0] spc_byte_t;
endpackage
`default_nettype wire

// File: spc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spc_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: spc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(parameter int WIDTH = 3, parameter logic [WIDTH-1:0] RST_VAL = '0)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    ////////////////////////////////////////////////////////////////////////
    // two flops; only the second stage is ever read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // spc_sync
`default_nettype wire

// File: spc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module spc_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 8)
(
    input wire logic clk,
    input wire logic rst_b,
    spc_stream_if.snk wr,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] cnt, next_cnt;
    logic next_out_valid, push, load;
    ////////////////////////////////////////////////////////////////////////
    // pointers; output register refills whenever it is empty or drained
    always_comb
    begin
        push = wr.valid && wr.ready;
        load = (cnt != '0) && (!out_valid || out_ready);
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = load ? rptr + 1'b1 : rptr;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(load);
        next_out_valid = load || (out_valid && !out_ready);
    end
    assign wr.ready = (cnt != (AW+1)'(DEPTH)); // honest full

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt <= next_cnt;
            out_valid <= next_out_valid;
        end
    end

    // storage without reset, read data registered
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wptr] <= wr.data;
        if (load)
            out_data <= mem[rptr];
    end
endmodule // spc_fifo
`default_nettype wire

// File: spc_client.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
module spc_client
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic engine_enable,
    input wire logic [1:0] mode,
    input wire logic bit_order_select,
    input wire logic buffer_mode_enable,
    input wire logic buffer_wait_receive,
    input wire logic miso_dir_out,
    input wire logic sck_pin,
    input wire logic ss_b_pin,
    input wire logic mosi_pin,
    output logic miso_out,
    output logic miso_oe_b,
    input wire logic data_write,
    input wire logic [7:0] data_in,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_full,
    output logic [`SPC_NFLAGS-1:0] flag_register,
    input wire logic [`SPC_NFLAGS-1:0] flag_clear,
    input wire logic [`SPC_NFLAGS-1:0] int_enable,
    output logic irq,
    output logic sck_event
);
    ////////////////////////////////////////////////////////////////////////
    // bit shift helper, used for receive assembly and setup shifting
    function automatic spc_byte_t shift_in(spc_byte_t b, logic bit_in, logic lsb_first);
        shift_in = lsb_first ? {bit_in, b[7:1]} : {b[6:0], bit_in};
    endfunction

    logic sck_s, ss_b_s, mosi_s, sck_q, ss_act_q;
    logic ss_act, ss_fall, ss_rise, sck_rise, sck_fall, lead, trail, samp, setup;
    logic last, busy, done, txc_ok, next_txc_ok;
    spc_byte_t shreg, next_shreg, txbuf, next_txbuf, rx_byte;
    logic txfull, next_txfull, preload, next_preload, pend, next_pend, hold, next_hold;
    logic [2:0] cnt, next_cnt;
    logic [`SPC_NFLAGS-1:0] flags, next_flags, src_mask;
    spc_state_t state, next_state;

    spc_stream_if #(.WIDTH(`SPC_BYTE_BITS)) rx_if ();

    ////////////////////////////////////////////////////////////////////////
    // pins are inputs whatever the port direction says
    // reset to the deselected level so no false select edge follows reset
    spc_sync #(.WIDTH(3), .RST_VAL(3'b010)) u_sync
    (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({sck_pin, ss_b_pin, mosi_pin}),
        .sync_out({sck_s, ss_b_s, mosi_s})
    );

    // received bytes; a full queue drops the byte since the host cannot stall
    spc_fifo #(.WIDTH(`SPC_BYTE_BITS), .DEPTH(`SPC_RX_DEPTH)) u_rx_fifo
    (
        .clk(clk),
        .rst_b(rst_b),
        .wr(rx_if.snk),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // edge detection on synchronized copies only
    always_comb
    begin
        ss_act = engine_enable && !ss_b_s;
        ss_fall = ss_act && !ss_act_q;
        ss_rise = !ss_act && ss_act_q;
        sck_rise = sck_s && !sck_q;
        sck_fall = !sck_s && sck_q;
        lead = mode[1] ? sck_fall : sck_rise;
        trail = mode[1] ? sck_rise : sck_fall;
        samp = ss_act && (mode[0] ? trail : lead);
        setup = ss_act && (mode[0] ? lead : trail);
        last = samp && (cnt == `SPC_LAST_BIT);
        done = last;
        busy = ss_act && ((cnt != 3'h0) || pend);
        rx_byte = shift_in(shreg, mosi_s, bit_order_select);
    end

    // every completed byte is offered; a full queue refuses it
    assign rx_if.valid = done;
    assign rx_if.data = rx_byte;
    assign rx_full = !rx_if.ready;
    assign sck_event = sck_s; // level event, stays >=2 cycles by host timing

    ////////////////////////////////////////////////////////////////////////
    // shifter, transmit buffer and flags
    always_comb
    begin
        next_shreg = shreg;
        next_txbuf = txbuf;
        next_txfull = txfull;
        next_preload = preload;
        next_pend = pend;
        next_hold = hold;
        next_cnt = cnt;
        next_txc_ok = txc_ok;
        next_flags = flags & ~(flag_clear & ~(6'h1 << `SPC_F_DRE));
        // capture and shift on opposite edges
        if (samp)
        begin
            next_hold = mosi_s;
            next_pend = 1'b1;
            next_cnt = cnt + 3'h1;
        end
        if (setup && pend)
        begin
            next_shreg = shift_in(shreg, hold, bit_order_select);
            next_pend = 1'b0;
        end
        // software writes
        if (data_write && !buffer_mode_enable)
        begin
            if (busy)
                next_flags[`SPC_F_WCOL] = 1'b1; // write dropped
            else
                next_shreg = data_in; // loads while idle, shifts later
        end
        else if (data_write && buffer_mode_enable)
        begin
            if (buffer_wait_receive && !ss_act && !preload && !txfull)
            begin
                next_shreg = data_in; // straight into shifter
                next_preload = 1'b1;
            end
            else if (!txfull)
            begin
                next_txbuf = data_in;
                next_txfull = 1'b1;
                next_flags[`SPC_F_DRE] = 1'b0;
            end
            // full buffer: write discarded
        end
        // byte complete; shifter keeps received byte as the next dummy, or takes txbuf when buffered mode has it full
        if (done)
        begin
            next_shreg = rx_byte;
            next_pend = 1'b0;
            next_cnt = 3'h0;
            next_txc_ok = !(buffer_mode_enable && txfull);
            if (!buffer_mode_enable)
                next_flags[`SPC_F_XFER] = 1'b1;
            if (buffer_mode_enable && txfull)
            begin
                next_shreg = txbuf;
                next_txfull = 1'b0;
                next_flags[`SPC_F_DRE] = 1'b1;
            end
        end
        if (buffer_mode_enable && ss_fall)
            next_flags[`SPC_F_SSI] = 1'b1;
        if (buffer_mode_enable && state == SPC_RXC)
            next_flags[`SPC_F_RXC] = 1'b1;
        if (buffer_mode_enable && state == SPC_TXC && txc_ok)
            next_flags[`SPC_F_TXC] = 1'b1;
        // deselect drops partial byte both ways
        if (!ss_act)
        begin
            next_cnt = 3'h0;
            next_pend = 1'b0;
        end
        if (ss_rise)
            next_preload = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer; rxc then txc follow a completed byte one cycle apart
    always_comb
    begin
        next_state = state;
        case (state)
            SPC_IDLE: if (ss_act) next_state = SPC_SHIFT;
            SPC_SHIFT: if (done) next_state = SPC_RXC;
            SPC_RXC: next_state = SPC_TXC;
            SPC_TXC: next_state = SPC_SHIFT;
            default: next_state = SPC_IDLE;
        endcase
        if (!ss_act)
            next_state = SPC_IDLE;
    end

    // registers only; every decision lives in the next-value logic
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= SPC_IDLE;
            sck_q <= 1'b0;
            ss_act_q <= 1'b0;
            shreg <= `SPC_SHREG_RST;
            txbuf <= `SPC_SHREG_RST;
            txfull <= 1'b0;
            preload <= 1'b0;
            pend <= 1'b0;
            hold <= 1'b0;
            cnt <= 3'h0;
            txc_ok <= 1'b0;
            flags <= `SPC_FLAGS_RST;
        end
        else
        begin
            state <= next_state;
            sck_q <= sck_s;
            ss_act_q <= ss_act;
            shreg <= next_shreg;
            txbuf <= next_txbuf;
            txfull <= next_txfull;
            preload <= next_preload;
            pend <= next_pend;
            hold <= next_hold;
            cnt <= next_cnt;
            txc_ok <= next_txc_ok;
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; data-out is the register bit at the head of the shifter
    always_comb
    begin
        miso_out = bit_order_select ? shreg[0] : shreg[7];
        miso_oe_b = !(miso_dir_out && ss_act); // released while deselected
        src_mask = buffer_mode_enable ? `SPC_BUFFER_SRC : `SPC_NORMAL_SRC;
        irq = |(flags & int_enable & src_mask);
    end
    assign flag_register = flags;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_RXC_AFTER_DRE: assert property (
        buffer_mode_enable && $rose(flags[`SPC_F_DRE]) && ss_act && state == SPC_RXC
        |=> flags[`SPC_F_RXC])
        else $error("receive flag not one cycle after empty flag");
    AST_TXC_AFTER_RXC: assert property (
        buffer_mode_enable && state == SPC_RXC && ss_act && next_txc_ok == txc_ok && txc_ok
        ##1 ss_act |=> flags[`SPC_F_TXC])
        else $error("transfer complete flag late");
    AST_WCOL: assert property (
        !buffer_mode_enable && data_write && busy && !done && !(setup && pend)
        |=> flags[`SPC_F_WCOL] && shreg == $past(shreg))
        else $error("collision write not dropped");
    AST_IDLE_SS_HIGH: assert property (
        !ss_act ##1 !ss_act |-> cnt == 3'h0 && !pend && state == SPC_IDLE)
        else $error("shifting while deselected");
    AST_MISO_TRI: assert property (
        ss_b_s || !engine_enable || !miso_dir_out |-> miso_oe_b)
        else $error("data-out driven while deselected");
    AST_MISO_DRIVE: assert property (
        !ss_b_s && engine_enable && miso_dir_out |-> !miso_oe_b)
        else $error("data-out not driven while selected");
    AST_IF_BYTE: assert property (
        !buffer_mode_enable && last |=> flags[`SPC_F_XFER] && cnt == 3'h0)
        else $error("transfer flag missing after byte");
    AST_FULL_DISCARD: assert property (
        buffer_mode_enable && data_write && txfull && !done |=> txbuf == $past(txbuf))
        else $error("full transmit buffer overwritten");
    AST_SSI: assert property (
        buffer_mode_enable && ss_fall |=> flags[`SPC_F_SSI])
        else $error("select trigger flag missing");
    AST_IRQ: assert property (
        !buffer_mode_enable && flags[`SPC_F_XFER] && int_enable[`SPC_F_XFER] |-> irq)
        else $error("interrupt not raised");

    // buffered transmit path and shifter loads
    AST_DRE_CLEAR: assert property (
        buffer_mode_enable && data_write && !txfull
        && !(buffer_wait_receive && !ss_act && !preload) |=> !flags[`SPC_F_DRE])
        else $error("empty flag not cleared by buffer write");
    AST_DRE_SET: assert property (
        buffer_mode_enable && done && txfull
        |=> flags[`SPC_F_DRE] && !txfull && shreg == $past(txbuf))
        else $error("buffered byte not moved to shifter");
    AST_TXC_NOT_EARLY: assert property (
        buffer_mode_enable && done && txfull && !flags[`SPC_F_TXC]
        |=> ##2 !flags[`SPC_F_TXC])
        else $error("transfer complete set with buffer still pending");
    AST_NORMAL_LOAD: assert property (
        !buffer_mode_enable && data_write && !busy
        |=> shreg == $past(data_in))
        else $error("idle write did not load the shifter");
    AST_PRELOAD: assert property (
        buffer_mode_enable && buffer_wait_receive && data_write && !ss_act && !preload && !txfull
        |=> preload && shreg == $past(data_in))
        else $error("deselected write did not reach the shifter");
    // deselect, interrupt masking and the clock event
    AST_SS_RISE_RESET: assert property (
        ss_rise
        |=> cnt == 3'h0 && !pend && state == SPC_IDLE)
        else $error("deselect did not reset the bit counter");
    AST_IRQ_BUF_MASK: assert property (
        buffer_mode_enable
        && !(|(flags[`SPC_F_TXC:`SPC_F_SSI] & int_enable[`SPC_F_TXC:`SPC_F_SSI])) |-> !irq)
        else $error("normal-mode source raised interrupt in buffered mode");
    AST_SCK_EVENT_LEN: assert property (
        $changed(sck_event)
        |=> $stable(sck_event))
        else $error("clock event shorter than two cycles");

    COV_NORMAL_BYTE: cover property (!buffer_mode_enable && done);
    COV_BUFFER_COPY: cover property (buffer_mode_enable && done && txfull);
    COV_PRELOAD: cover property (buffer_wait_receive && data_write && !ss_act ##1 preload);
    COV_ABORT: cover property (ss_rise && cnt != 3'h0);
    COV_WCOL: cover property (!buffer_mode_enable && data_write && busy);
endmodule // spc_client
`default_nettype wire

// File: spc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural serial host: drives clock, select and data-out, samples data-in
module spc_host_model
(
    output logic sck,
    output logic ss_b,
    output logic mosi,
    input wire logic miso,
    input wire logic [1:0] mode,
    input wire logic lsb_first
);
    // clock stands at idle level outside frames
    initial
    begin
        sck = 1'b0;
        ss_b = 1'b1;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one frame; nb under 8 aborts mid-byte, sel 0 clocks with select held high
    task automatic xfer(input logic [7:0] tx, input int nb, input logic sel,
        output logic [7:0] rx);
        int b;
        rx = 8'h00;
        sck = mode[1];
        #100;
        ss_b = ~sel;
        #100;
        for (int i = 0; i < nb; i++)
        begin
            b = lsb_first ? i : 7 - i;
            if (mode[0])
                sck = ~sck;
            mosi = tx[b];
            #40; // phases of 40 ns, four engine clocks
            sck = ~sck;
            rx[b] = miso;
            #40;
            if (!mode[0])
                sck = ~sck;
        end
        #100;
        ss_b = 1'b1;
        // released line: show the inverse, never the last bit
        mosi = ~mosi;
        #200;
    endtask
endmodule // spc_host_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_b, bit_order_select, buffer_mode_enable, buffer_wait_receive;
    logic sck_pin, ss_b_pin, mosi_pin, miso_out, miso_oe_b, data_write, rx_valid;
    logic rx_ready, rx_full, irq, sck_event, drain, miso_dir_out, miso_line;
    logic [1:0] mode;
    logic [7:0] data_in, rx_data, d, m, a, r;
    logic [5:0] flag_register, flag_clear, int_enable;
    logic [7:0] q[$];
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;

    spc_client u_dut (.clk(clk), .rst_b(rst_b), .engine_enable(1'b1), .mode(mode),
        .bit_order_select(bit_order_select), .buffer_mode_enable(buffer_mode_enable),
        .buffer_wait_receive(buffer_wait_receive), .miso_dir_out(miso_dir_out),
        .sck_pin(sck_pin), .ss_b_pin(ss_b_pin), .mosi_pin(mosi_pin), .miso_out(miso_out),
        .miso_oe_b(miso_oe_b), .data_write(data_write), .data_in(data_in),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_full(rx_full),
        .flag_register(flag_register), .flag_clear(flag_clear), .int_enable(int_enable),
        .irq(irq), .sck_event(sck_event));
    spc_host_model u_host (.sck(sck_pin), .ss_b(ss_b_pin), .mosi(mosi_pin),
        .miso(miso_line), .mode(mode), .lsb_first(bit_order_select));
    // released data-out shows the inverse, so a late drive corrupts the byte
    assign miso_line = miso_oe_b ? ~miso_out : miso_out;

    // 100 MHz engine clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one-cycle write pulse on the falling edge; callers write between frames, except the collision write during a busy frame
    task automatic wr(input logic [7:0] v);
        @(negedge clk);
        data_write = 1'b1;
        data_in = v;
        @(negedge clk);
        data_write = 1'b0;
    endtask

    task automatic clr(input logic [5:0] f);
        @(negedge clk);
        flag_clear = f;
        @(negedge clk);
        flag_clear = 6'h00;
    endtask

    // full frame; psh notes the byte the receive side should deliver
    task automatic xf(input logic [7:0] tx, input logic [7:0] exp, input logic psh);
        logic [7:0] rx;
        if (psh)
            q.push_back(tx);
        u_host.xfer(tx, 8, 1'b1, rx);
        cmp(rx, exp, "miso");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // receive side: oldest note against each popped byte
    always @(posedge clk)
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
        begin
            if (q.size() != 0)
                cmp(rx_data, q.pop_front(), "rx");
            else
                cmp(8'h00, 8'h01, "rx extra");
        end

    // random stall of the reader once draining starts
    always @(negedge clk)
        rx_ready <= drain & (($urandom % 4) != 0);

    // hang guard, tests need about 2300 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_b, bit_order_select, buffer_mode_enable, buffer_wait_receive} = 4'h0;
        {data_write, drain, mode, data_in} = 12'h000;
        miso_dir_out = 1'b1;
        {flag_clear, int_enable} = 12'h000;
        void'($urandom(52));
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        cmp({2'h0, flag_register}, 8'h08, "flags rst");
        cmp({7'h0, miso_oe_b}, 8'h01, "oe idle");
        // every clock mode in both bit orders; reader stalled to fill the fifo
        for (int k = 0; k < 8; k++)
        begin
            mode = k[1:0];
            bit_order_select = k[2];
            d = 8'($urandom);
            m = 8'($urandom);
            wr(d);
            xf(m, d, 1'b1);
            cmp({7'h0, flag_register[0]}, 8'h01, "xfer flag");
            clr(6'h01);
            cmp({7'h0, sck_event}, {7'h0, mode[1]}, "event");
        end
        // write during a busy frame is dropped; this byte fills the receive queue
        d = 8'($urandom);
        m = 8'($urandom);
        wr(d);
        fork
            xf(m, d, 1'b1);
            begin
                #400;
                wr(~d);
                cmp({7'h0, miso_oe_b}, 8'h00, "oe sel");
            end
        join
        cmp({7'h0, rx_full}, 8'h01, "full");
        cmp({6'h0, flag_register[1:0]}, 8'h03, "wcol");
        @(negedge clk);
        int_enable = 6'h02;
        #1 cmp({7'h0, irq}, 8'h01, "irq on");
        clr(6'h03);
        cmp({7'h0, irq}, 8'h00, "irq off");
        drain = 1'b1;
        // clocks with select high shift nothing
        d = 8'($urandom);
        wr(d);
        u_host.xfer(~d, 8, 1'b0, r);
        cmp({7'h0, flag_register[0]}, 8'h00, "idle");
        xf(8'($urandom), d, 1'b1);
        // aborted half byte, then a clean byte
        fork
            u_host.xfer(8'ha5, 4, 1'b1, r);
            begin
                #300;
                @(negedge clk);
                miso_dir_out = 1'b0;
                @(negedge clk);
                cmp({7'h0, miso_oe_b}, 8'h01, "oe input");
                miso_dir_out = 1'b1;
            end
        join
        d = 8'($urandom);
        m = 8'($urandom);
        wr(d);
        xf(m, d, 1'b1);
        // buffered, no wait: dummy first, full buffer refuses
        @(negedge clk);
        buffer_mode_enable = 1'b1;
        clr(6'h3f);
        int_enable = 6'h10;
        a = 8'($urandom);
        wr(a);
        cmp({7'h0, flag_register[3]}, 8'h00, "dre low");
        wr(~a);
        xf(8'($urandom), m, 1'b1);
        cmp({4'h0, flag_register[5:2]}, 8'h07, "buf flags");
        cmp({7'h0, irq}, 8'h01, "irq rxc");
        xf(8'($urandom), a, 1'b1);
        cmp({7'h0, flag_register[5]}, 8'h01, "txc");
        // buffered with wait: first write straight to the shifter
        @(negedge clk);
        buffer_wait_receive = 1'b1;
        clr(6'h3f);
        a = 8'($urandom);
        d = 8'($urandom);
        wr(a);
        wr(d);
        wr(~d);
        xf(8'($urandom), a, 1'b1);
        xf(8'($urandom), d, 1'b1);
        repeat (300) @(negedge clk);
        cmp(8'(q.size()), 8'h00, "rx left");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
